// ==== src/css_seq.v ====
`timescale 1ns/1ps
`include "css_map.vh"
// Function
// [R1] Completion driven in selectable phase, default 4
// [R2] Pipelined completion waits pin high plus edge
// [R3] Output release in selectable phase, default 5
// [R4] Write enable in selectable phase, default 6
// [R5] Block RAM access blocked before write enable
// [R6] Stall in lock phase until clocks lock
// [R7] CRC mismatch aborts configuration
// [R8] CRC off: constant slot, no check
// [R9] Security levels gate readback and reconfiguration
// [R10] Live reconfig suppresses hold and set-reset
// [R11] Load 32-bit user word for fabric
// [R12] Timestamp layout day month year hour min sec
// [R13] Test port to scan block optionally blocked
// [R14] Monitor ADC test access: full, off, status
// [R15] Monitor ADC safe mode during partial reconfig
// [R16] Route config port top, bottom or auto
// [R17] Key source battery RAM or fuses
// [R18] Sequence clock: config, fabric or test clock
// [R19] Stall in match phase until impedance matched
// [R20] Advance one phase per sequence tick
// [R21] Keep setting leaves signal unchanged
module css_seq (
    input  wire        clk,                   // 200 MHz system clock
    input  wire        rstn,                  // Async active-low reset
    // Bitstream word stream
    input  wire        cfg_start,             // Begin a (re)configuration
    input  wire        word_vld,              // Bitstream word valid
    input  wire [31:0] word_data,             // Bitstream word
    input  wire        word_is_crc,           // Word is the CRC slot
    input  wire        word_is_user,          // Word is the user word
    input  wire        word_last,             // Last word before startup
    input  wire        partial,               // This load is partial
    // Bitstream options
    input  wire        crc_enable,            // CRC checking on
    input  wire        completion_pipelining, // Wait on pin before done
    input  wire [3:0]  done_phase_sel,        // Completion phase or keep
    input  wire [3:0]  output_release_phase,  // 3-state release phase
    input  wire [3:0]  write_enable_phase,    // Global write enable phase
    input  wire [3:0]  lock_wait_phase,       // Lock wait phase or skip_wait
    input  wire [3:0]  match_phase,           // Impedance match phase or skip
    input  wire [1:0]  security_level,        // None, readback_lock, full_lock
    input  wire        live_reconfig_option,  // Keep hold/set-reset idle
    input  wire        test_port_disable,     // Block scan after completion
    input  wire [1:0]  monitor_adc_mode,      // Test-port path to ADC
    input  wire        monitor_adc_safe_pr,   // Safe mode in partial loads
    input  wire [1:0]  config_port_choice,    // Auto, top or bottom
    input  wire        key_from_fuse,         // Key source select
    input  wire [1:0]  sequence_clock_select, // Startup tick source
    input  wire        cfg_clk_pin,           // Configuration clock
    input  wire        fabric_clock,          // Fabric-supplied clock
    input  wire        test_port_clock,       // Test-port clock
    input  wire        done_pin,              // Completion pin readback
    input  wire        clocks_locked,         // All clock managers locked
    input  wire        impedance_matched,     // Calibration matched
    input  wire        readback_req,          // Readback requested
    input  wire        auto_port_bottom,      // Auto choice picks bottom
    output reg         done_ff,               // Completion indication
    output reg         tristate_ff,           // Global I/O 3-state active
    output reg         write_enable_ff,       // Global write enable
    output wire        bram_access_en,        // Block RAM read/write allowed
    output reg         interconnect_hold_high,// Global interconnect hold
    output reg         global_set_reset,      // Global set-reset
    output reg         cfg_error_ff,          // CRC abort
    output reg  [31:0] user_word_register,    // Word seen by fabric reader
    output wire        readback_grant,        // Readback allowed
    output wire        reconfig_refused,      // New loads refused
    output wire        scan_path_en,          // Test port to scan block
    output wire        adc_full_en,           // ADC full test access
    output wire        adc_status_en,         // ADC status test access
    output wire        adc_safe_mode,         // ADC in safe mode
    output wire        port_top_sel,          // Top config port active
    output wire        port_bot_sel,          // Bottom config port active
    output wire        key_fuse_sel,          // Key from fuse store
    output reg  [2:0]  phase_ff               // Current startup phase
);
    localparam ST_IDLE  = 2'h0;               // Awaiting a load
    localparam ST_LOAD  = 2'h1;               // Receiving words
    localparam ST_START = 2'h2;               // Startup phases
    localparam ST_ABORT = 2'h3;               // Failed CRC

    reg  [1:0]  state_ff;                     // Main state
    reg  [1:0]  nxt_state;
    reg         rst_m_ff;                     // Reset sync stage 1
    reg         rst_s_ff;                     // Reset sync stage 2
    wire        rst_n;                        // Synchronised reset
    reg  [2:0]  tk_a_ff;                      // Tick source sync chain
    reg  [2:0]  dn_ff;                        // Done pin sync chain
    reg  [2:0]  lk_ff;                        // Lock sync chain
    reg  [2:0]  mt_ff;                        // Match sync chain
    reg         tk_lvl_ff;                    // Accepted tick level
    reg         done_seen_ff;                 // Pin high seen once
    reg         partial_ff;                   // Partial load latched
    reg         ever_cfg_ff;                  // A load has completed
    reg         tick_src;                     // Selected raw tick
    wire        tick;                         // One-cycle startup tick
    wire        done_pin_s;                   // Filtered done pin
    wire        lock_s;                       // Filtered lock
    wire        match_s;                      // Filtered match
    wire [31:0] crc_val;                      // Running CRC
    wire        crc_fold;                     // Fold word into CRC
    wire        stall;                        // Phase held this tick

    // Two-flop reset release
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_m_ff <= 1'b0;
            rst_s_ff <= 1'b0;
        end else begin
            rst_m_ff <= 1'b1;
            rst_s_ff <= rst_m_ff;
        end
    end
    assign rst_n = rst_s_ff;

    // Match a select code against the phase we just entered
    function hit;
        input [3:0] sel;
        input [2:0] ph;
        begin
            hit = (sel[3] == 1'b0) && (sel[2:0] == ph);
        end
    endfunction

    // Tick source mux; all three are foreign to clk
    always @* begin
        case (sequence_clock_select) // [R18]
            `CSS_CLK_FAB:  tick_src = fabric_clock;
            `CSS_CLK_TEST: tick_src = test_port_clock;
            default:       tick_src = cfg_clk_pin;
        endcase
    end

    // Three-flop input chains; tick level changes when stages 2 and 3 agree, the others read high only with both high
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tk_a_ff   <= 3'h0;
            dn_ff     <= 3'h0;
            lk_ff     <= 3'h0;
            mt_ff     <= 3'h0;
            tk_lvl_ff <= 1'b0;
        end else begin
            tk_a_ff <= {tk_a_ff[1:0], tick_src};
            dn_ff   <= {dn_ff[1:0], done_pin};
            lk_ff   <= {lk_ff[1:0], clocks_locked};
            mt_ff   <= {mt_ff[1:0], impedance_matched};
            if (tk_a_ff[1] == tk_a_ff[2])
                tk_lvl_ff <= tk_a_ff[2];
        end
    end
    // Rising edge of the accepted tick level
    assign tick       = (tk_a_ff[1] == tk_a_ff[2]) && tk_a_ff[2] && !tk_lvl_ff;
    assign done_pin_s = dn_ff[1] & dn_ff[2];
    assign lock_s     = lk_ff[1] & lk_ff[2];
    assign match_s    = mt_ff[1] & mt_ff[2];

    // CRC fold skips the slot itself and is off when checking is off
    assign crc_fold = (state_ff == ST_LOAD) && word_vld && !word_is_crc && crc_enable; // [R8]

    css_crc u_crc (
        .clk    (clk),
        .rst_n  (rst_n),
        .clr    (cfg_start),
        .en     (crc_fold),
        .data   (word_data),
        .crc_ff (crc_val)
    );

    // Waits hold the phase; a SKIP_WAIT code never matches a phase
    assign stall = (hit(lock_wait_phase, phase_ff) && !lock_s) // [R6]
                 || (hit(match_phase, phase_ff) && !match_s);  // [R19]

    // Main state transitions
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                // Full lock refuses any load once one has completed
                if (cfg_start && !(ever_cfg_ff && security_level == `CSS_SEC_FULL)) // [R9]
                    nxt_state = ST_LOAD;
            end
            ST_LOAD: begin
                if (word_vld && word_is_crc && crc_enable && (word_data != crc_val))
                    nxt_state = ST_ABORT; // [R7]
                else if (word_vld && word_last)
                    nxt_state = ST_START;
            end
            ST_START: begin
                if (phase_ff == `CSS_DONE_STATE)
                    nxt_state = ST_IDLE;
            end
            ST_ABORT: begin
                if (cfg_start)
                    nxt_state = ST_LOAD;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    // State, phase counter and user word
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff           <= ST_IDLE;
            phase_ff           <= 3'h0;
            cfg_error_ff       <= 1'b0;
            user_word_register <= 32'h00000000;
            partial_ff         <= 1'b0;
            ever_cfg_ff        <= 1'b0;
            done_seen_ff       <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff != ST_LOAD && nxt_state == ST_LOAD) begin
                phase_ff     <= 3'h0;
                cfg_error_ff <= 1'b0;
                partial_ff   <= partial;
                done_seen_ff <= 1'b0;
            end
            if (nxt_state == ST_ABORT)
                cfg_error_ff <= 1'b1; // [R7]
            // Word is opaque; timestamp packing is upstream
            if (state_ff == ST_LOAD && word_vld && word_is_user)
                user_word_register <= word_data; // [R11] [R12]
            if (state_ff == ST_START && tick && !stall) begin
                if (phase_ff == 3'h6) begin
                    // Pipelined completion needs pin high, then a further tick
                    if (!completion_pipelining || done_seen_ff) // [R2]
                        phase_ff <= `CSS_DONE_STATE;
                    else if (done_pin_s)
                        done_seen_ff <= 1'b1;
                end else if (phase_ff != `CSS_DONE_STATE) begin
                    phase_ff <= phase_ff + 3'h1; // [R20]
                end
            end
            if (state_ff == ST_START && phase_ff == `CSS_DONE_STATE)
                ever_cfg_ff <= 1'b1;
        end
    end

    // Startup outputs change when their phase is entered; keep never matches
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_ff                <= 1'b0;
            tristate_ff            <= 1'b1;
            write_enable_ff        <= 1'b0;
            interconnect_hold_high <= 1'b0;
            global_set_reset       <= 1'b0;
        end else begin
            if (state_ff != ST_LOAD && nxt_state == ST_LOAD) begin
                // Live reconfig leaves running logic alone
                if (!live_reconfig_option) begin // [R10]
                    interconnect_hold_high <= 1'b1;
                    global_set_reset       <= 1'b1;
                    write_enable_ff        <= 1'b0;
                    tristate_ff            <= 1'b1;
                    done_ff                <= 1'b0;
                end
            end
            if (state_ff == ST_START) begin
                global_set_reset <= 1'b0;
                if (hit(done_phase_sel, phase_ff)) // [R1] [R21]
                    done_ff <= 1'b1;
                if (hit(output_release_phase, phase_ff)) begin // [R3] [R21]
                    tristate_ff            <= 1'b0;
                    interconnect_hold_high <= 1'b0;
                end
                if (hit(write_enable_phase, phase_ff)) // [R4] [R21]
                    write_enable_ff <= 1'b1;
            end
        end
    end

    // Block RAMs stay dark until write enable arrives
    assign bram_access_en = write_enable_ff; // [R5]

    // Security gating of readback and reconfiguration
    assign readback_grant   = readback_req && (security_level == `CSS_SEC_NONE); // [R9]
    assign reconfig_refused = ever_cfg_ff && (security_level == `CSS_SEC_FULL); // [R9]

    // Scan path cut only after completion
    assign scan_path_en = !(test_port_disable && done_ff); // [R13]

    // Monitor ADC test-port modes
    assign adc_full_en   = (monitor_adc_mode == `CSS_ADC_FULL); // [R14]
    assign adc_status_en = (monitor_adc_mode == `CSS_ADC_FULL) || (monitor_adc_mode == `CSS_ADC_STATUS); // [R14]
    assign adc_safe_mode = monitor_adc_safe_pr && partial_ff && (state_ff != ST_IDLE); // [R15]

    // Config port routing; auto follows a hardware hint
    assign port_top_sel = (config_port_choice == `CSS_PORT_TOP)
                       || (config_port_choice == `CSS_PORT_AUTO && !auto_port_bottom); // [R16]
    assign port_bot_sel = (config_port_choice == `CSS_PORT_BOT)
                       || (config_port_choice == `CSS_PORT_AUTO && auto_port_bottom); // [R16]

    // Key source
    assign key_fuse_sel = key_from_fuse; // [R17]
endmodule // css_seq

// ==== src/css_map.vh ====
`ifndef CSS_MAP_VH
`define CSS_MAP_VH
// Phase select encodings (4 bits): 0..6 phase number, 7 = done, keep/skip below
`define CSS_SEL_DONE      4'h7
`define CSS_SEL_KEEP      4'h8
`define CSS_SEL_SKIP_WAIT    4'hF
`define CSS_DONE_DEF      4'h4
`define CSS_GTS_DEF       4'h5
`define CSS_GWE_DEF       4'h6
`define CSS_DONE_STATE    3'h7
// Security levels
`define CSS_SEC_NONE      2'h0
`define CSS_SEC_RB        2'h1
`define CSS_SEC_FULL      2'h2
// Monitor ADC access modes
`define CSS_ADC_FULL      2'h0
`define CSS_ADC_OFF       2'h1
`define CSS_ADC_STATUS    2'h2
// Config port choice
`define CSS_PORT_AUTO     2'h0
`define CSS_PORT_TOP      2'h1
`define CSS_PORT_BOT      2'h2
// Sequence clock select
`define CSS_CLK_CFG       2'h0
`define CSS_CLK_FAB       2'h1
`define CSS_CLK_TEST      2'h2
// Constant placed in the CRC slot when checking is off
`define CSS_CRC_CONST     32'hDEFC9DEF
`define CSS_CRC_POLY      32'h1EDC6F41
`define CSS_CRC_INIT      32'h00000000
`endif

// ==== src/css_crc.v ====
`timescale 1ns/1ps
`include "css_map.vh"
// Serial-in-word CRC32C accumulator over bitstream words
module css_crc (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        clr,       // Restart accumulation
    input  wire        en,        // Fold in one word
    input  wire [31:0] data,      // Word to fold
    output reg  [31:0] crc_ff     // Running CRC value
);
    // One word per cycle; loop unrolls combinationally
    function [31:0] crc_word;
        input [31:0] c;
        input [31:0] d;
        integer i;
        reg [31:0] r;
        begin
            r = c;
            for (i = 31; i >= 0; i = i - 1)
                r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `CSS_CRC_POLY : 32'h00000000);
            crc_word = r;
        end
    endfunction

    // Accumulator register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_ff <= `CSS_CRC_INIT;
        end else if (clr) begin
            crc_ff <= `CSS_CRC_INIT;
        end else if (en) begin
            crc_ff <= crc_word(crc_ff, data);
        end
    end
endmodule // css_crc

// ==== bench/css_seq_chk.sv ====
`timescale 1ns/1ps
`include "css_map.vh"
// Port-level checker for the startup sequencer
module css_seq_chk (
    input wire       clk,
    input wire       rstn,
    input wire [2:0] phase_ff,
    input wire [3:0] done_phase_sel,
    input wire [3:0] output_release_phase,
    input wire [3:0] write_enable_phase,
    input wire [3:0] lock_wait_phase,
    input wire       clocks_locked,
    input wire       done_ff,
    input wire       tristate_ff,
    input wire       write_enable_ff,
    input wire       bram_access_en,
    input wire       interconnect_hold_high,
    input wire       global_set_reset,
    input wire       live_reconfig_option
);
    wire [3:0] ph4 = {1'b0, phase_ff}; // Phase at select width
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Block RAM gate never opens ahead of the write enable
    property p_bram; bram_access_en == write_enable_ff; endproperty
    a_bram: assert property (p_bram) else $error("block RAM gate differs from write enable");
    // Phase only steps by one or restarts at zero
    property p_step; phase_ff != $past(phase_ff) |-> phase_ff == $past(phase_ff) + 3'h1 || phase_ff == 3'h0; endproperty
    a_step: assert property (p_step) else $error("phase jumped");
    // Completion follows one cycle after entering its phase
    property p_done; $rose(ph4 == done_phase_sel) |=> done_ff; endproperty
    a_done: assert property (p_done) else $error("completion late");
    // Outputs leave three-state only at the chosen phase
    property p_rel; $fell(tristate_ff) |-> ph4 == output_release_phase
        || $past(ph4) == output_release_phase; endproperty
    a_rel: assert property (p_rel) else $error("release at wrong phase");
    property p_gwe; $rose(write_enable_ff) |-> ph4 == write_enable_phase
        || $past(ph4) == write_enable_phase; endproperty
    a_gwe: assert property (p_gwe) else $error("write enable at wrong phase");
    property p_keep; done_phase_sel == `CSS_SEL_KEEP |-> !$rose(done_ff); endproperty
    a_keep: assert property (p_keep) else $error("kept completion changed");
    // Unlocked for four cycles: filter still low, no step
    property p_lock; (!clocks_locked && ph4 == lock_wait_phase) [*4] |=> $stable(phase_ff); endproperty
    a_lock: assert property (p_lock) else $error("left lock phase unlocked");
    property p_live; $rose(global_set_reset || interconnect_hold_high) |-> !live_reconfig_option; endproperty
    a_live: assert property (p_live) else $error("hold or set-reset under live reconfig");
    c_done: cover property (phase_ff == 3'h7);
    c_stall: cover property (!clocks_locked && ph4 == lock_wait_phase);
    c_keep: cover property (done_phase_sel == `CSS_SEL_KEEP && phase_ff == 3'h7);
endmodule // css_seq_chk

bind css_seq css_seq_chk i_css_seq_chk (.*);

// ==== bench/css_src.sv ====
`timescale 1ns/1ps
`include "css_map.vh"
// Bitstream source and startup tick sources facing the sequencer
module css_src (
    input  wire        clk,
    input  wire        done_ff,
    output reg         word_vld,
    output reg  [31:0] word_data,
    output reg         word_is_crc,
    output reg         word_is_user,
    output reg         word_last,
    output reg         cfg_clk_pin,
    output reg         fabric_clock,
    output reg         test_port_clock,
    output wire        done_pin
);
    // Open-drain pin with pull-up reads high once the device lets go
    assign done_pin = done_ff;
    initial begin
        {word_vld, word_is_crc, word_is_user, word_last} = 4'h0;
        word_data = 32'h0;
        {test_port_clock, fabric_clock, cfg_clk_pin} = 3'h0;
    end
    // Reference CRC, msb first
    function [31:0] crc_word(input [31:0] c, input [31:0] d);
        integer i;
        begin
            crc_word = c;
            for (i = 31; i >= 0; i = i - 1)
                crc_word = {crc_word[30:0], 1'b0} ^ ((crc_word[31] ^ d[i]) ? `CSS_CRC_POLY : 32'h0);
        end
    endfunction
    // Words 0..4 with user word at 2, CRC slot at 5, closing word at 6
    task send(input [31:0] uw, input [31:0] base, input ce, input bad);
        reg [31:0] c, w;
        integer    n;
        begin
            c = `CSS_CRC_INIT;
            for (n = 0; n < 7; n = n + 1) begin
                w = (n == 2) ? uw : base ^ (n * 32'h01010101);
                if (n == 5)
                    w = (ce ? c : `CSS_CRC_CONST) ^ {32{bad}};
                else
                    c = crc_word(c, w);
                @(posedge clk);
                {word_vld, word_is_user, word_is_crc, word_last} <= {1'b1, n == 2, n == 5, n == 6};
                word_data <= w;
            end
            @(posedge clk);
            {word_vld, word_is_user, word_is_crc, word_last} <= 4'h0;
            // Released bus shows the inverse so stale data cannot pass
            word_data <= ~w;
        end
    endtask
    // One tick on source s; sources stand still between ticks
    task tick(input [1:0] s);
        begin
            @(posedge clk);
            {test_port_clock, fabric_clock, cfg_clk_pin} <= 3'h1 << s;
            repeat (6) @(posedge clk);
            {test_port_clock, fabric_clock, cfg_clk_pin} <= 3'h0;
            repeat (6) @(posedge clk);
        end
    endtask
endmodule // css_src

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`include "css_map.vh"
module tb;
    reg         clk, rstn, cfg_start, partial, crc_enable, completion_pipelining, live_reconfig_option;
    reg         test_port_disable, monitor_adc_safe_pr, key_from_fuse, clocks_locked, impedance_matched;
    reg         readback_req, auto_port_bottom;
    reg  [3:0]  done_phase_sel, output_release_phase, write_enable_phase, lock_wait_phase, match_phase;
    reg  [1:0]  security_level, monitor_adc_mode, config_port_choice, sequence_clock_select;
    reg  [31:0] rv;
    wire        word_vld, word_is_crc, word_is_user, word_last, cfg_clk_pin, fabric_clock, test_port_clock;
    wire        done_pin, done_ff, tristate_ff, write_enable_ff, bram_access_en, interconnect_hold_high;
    wire        global_set_reset, cfg_error_ff, readback_grant, reconfig_refused, scan_path_en, adc_full_en;
    wire        adc_status_en, adc_safe_mode, port_top_sel, port_bot_sel, key_fuse_sel;
    wire [31:0] word_data, user_word_register;
    wire [2:0]  phase_ff;
    integer     mismatches, n_tests, seed, cyc, ph, k, t, flag;
    css_seq i_css_seq (.*);
    css_src i_css_src (.*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard: all runs together take under two thousand cycles
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    end
    function [3:0] rnd(input integer n);
        integer x;
        begin
            x = {$random(seed)} % n;
            rnd = x[3:0];
        end
    endfunction
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("ERROR t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("Checks %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task do_reset;
        begin
            @(posedge clk) rstn <= 1'b0;
            repeat (20) @(posedge clk);
            rstn <= 1'b1;
            repeat (3) @(posedge clk);
            chk({tristate_ff, done_ff, write_enable_ff, phase_ff}, 32'h20);
        end
    endtask
    // Signal due: phase reached and not kept
    function at(input [3:0] s);
        at = s != `CSS_SEL_KEEP && ph >= s;
    endfunction
    // Model steps one phase per tick unless a wait stalls it
    task startup;
        begin
            flag = 0;
            for (k = 0; k < 14 && ph != 7; k = k + 1) begin
                if (k == 3) begin
                    @(posedge clk) {clocks_locked, impedance_matched} <= 2'h3;
                    repeat (4) @(posedge clk);
                end
                if (k == 1) i_css_src.tick(sequence_clock_select + 2'h1);
                i_css_src.tick(sequence_clock_select);
                @(negedge clk);
                if (!((ph == lock_wait_phase || ph == match_phase) && !clocks_locked)) begin
                    if (ph == 6 && completion_pipelining && !flag) flag = 1;
                    else ph = ph + 1;
                end
                chk(phase_ff, ph);
                chk(done_ff, at(done_phase_sel));
                chk(tristate_ff, !at(output_release_phase));
                chk(write_enable_ff, at(write_enable_phase));
                chk(bram_access_en, at(write_enable_phase));
            end
            chk(readback_grant, readback_req && security_level == `CSS_SEC_NONE);
            chk(reconfig_refused, security_level == `CSS_SEC_FULL);
            chk(scan_path_en, !(test_port_disable && at(done_phase_sel)));
            chk({adc_full_en, adc_status_en}, {monitor_adc_mode == `CSS_ADC_FULL, monitor_adc_mode != `CSS_ADC_OFF});
            chk(port_top_sel, config_port_choice == `CSS_PORT_TOP || (config_port_choice == 2'h0 && !auto_port_bottom));
            chk(port_bot_sel, config_port_choice == `CSS_PORT_BOT || (config_port_choice == 2'h0 && auto_port_bottom));
            chk(key_fuse_sel, key_from_fuse);
        end
    endtask
    task run(input bad, input [31:0] uw);
        begin
            ph = 0;
            @(posedge clk) cfg_start <= 1'b1;
            {clocks_locked, impedance_matched} <= 2'h0;
            @(posedge clk) cfg_start <= 1'b0;
            repeat (2) @(negedge clk);
            chk(global_set_reset, !live_reconfig_option);
            chk(adc_safe_mode, partial && monitor_adc_safe_pr);
            i_css_src.send(uw, $random(seed), crc_enable, bad);
            repeat (3) @(negedge clk);
            chk(cfg_error_ff, bad && crc_enable);
            if (!(bad && crc_enable)) begin
                chk(user_word_register, uw);
                startup;
            end
            $display("Test ended at phase %0d", ph);
        end
    endtask
    // Random options; live reconfig has its own run
    task shuffle;
        begin
            rv = $random(seed);
            @(posedge clk) completion_pipelining <= rv[14];
            done_phase_sel <= (!rv[14] && rv[15]) ? `CSS_SEL_KEEP : rnd(6) + 4'h1;
            output_release_phase <= rnd(8) + 4'h1;
            write_enable_phase <= rnd(8) + 4'h1;
            lock_wait_phase <= rv[16] ? `CSS_SEL_SKIP_WAIT : rnd(7);
            match_phase <= rv[17] ? `CSS_SEL_SKIP_WAIT : rnd(7);
            {partial, monitor_adc_safe_pr, test_port_disable, key_from_fuse, readback_req, auto_port_bottom} <= rv[5:0];
            security_level <= {1'b0, rv[6]};
            monitor_adc_mode <= (rv[9:8] == 2'h3) ? 2'h2 : rv[9:8];
            config_port_choice <= (rv[11:10] == 2'h3) ? 2'h0 : rv[11:10];
            sequence_clock_select <= (rv[13:12] == 2'h3) ? 2'h1 : rv[13:12];
        end
    endtask
    initial begin
        {rstn, cfg_start, partial, live_reconfig_option, test_port_disable, monitor_adc_safe_pr} = 6'h0;
        {key_from_fuse, clocks_locked, impedance_matched, readback_req, auto_port_bottom} = 5'h0;
        {crc_enable, completion_pipelining} = 2'h3;
        {done_phase_sel, output_release_phase, write_enable_phase} = {`CSS_DONE_DEF, `CSS_GTS_DEF, `CSS_GWE_DEF};
        {lock_wait_phase, match_phase} = {`CSS_SEL_SKIP_WAIT, `CSS_SEL_SKIP_WAIT};
        {security_level, monitor_adc_mode, config_port_choice, sequence_clock_select} = 8'h0;
        seed = 91021;
        {mismatches, n_tests, cyc} = 96'h0;
        do_reset;
        run(1'b0, $random(seed));
        run(1'b0, {5'h11, 4'h9, 6'h18, 5'h0D, 6'h2D, 6'h1E});
        for (t = 0; t < 6; t = t + 1) begin
            shuffle;
            run(1'b0, $random(seed));
        end
        run(1'b1, $random(seed));
        run(1'b0, $random(seed));
        @(posedge clk) crc_enable <= 1'b0;
        lock_wait_phase <= 4'h2;
        run(1'b1, $random(seed));
        do_reset;
        @(posedge clk) security_level <= `CSS_SEC_FULL;
        {live_reconfig_option, completion_pipelining, done_phase_sel} <= {2'h2, `CSS_SEL_KEEP};
        run(1'b0, $random(seed));
        @(posedge clk) cfg_start <= 1'b1;
        @(posedge clk) cfg_start <= 1'b0;
        repeat (3) @(negedge clk);
        chk(phase_ff, 3'h7);
        do_reset;
        wrap_up;
    end
endmodule // tb
